/* twt_regs.svh */
// Purpose: register offsets, field positions, reset values of the two-wire target
// Assumes: byte addresses on a 12-bit wishbone address
// Notes:   definitions only
`ifndef TWT_REGS_SVH
`define TWT_REGS_SVH

// ----------------------------------------
// offsets
// ----------------------------------------
`define TWT_OFS_ERRSRC   12'h4d0
`define TWT_OFS_MATCH    12'h4d4
`define TWT_OFS_ENABLE   12'h500
`define TWT_OFS_SCLSEL   12'h508
`define TWT_OFS_SDASEL   12'h50c
`define TWT_OFS_RXPTR    12'h534
`define TWT_OFS_RXMAX    12'h538
`define TWT_OFS_RXAMT    12'h53c
`define TWT_OFS_RXLIST   12'h540
`define TWT_OFS_TXPTR    12'h544
`define TWT_OFS_TXMAX    12'h548
`define TWT_OFS_TXAMT    12'h54c
`define TWT_OFS_TXLIST   12'h550
`define TWT_OFS_ADDR0    12'h588
`define TWT_OFS_ADDR1    12'h58c
`define TWT_OFS_CONFIG   12'h594
`define TWT_OFS_ORC      12'h5c0
`define TWT_OFS_EVSTAT   12'h610
`define TWT_OFS_EVMASK   12'h614

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define TWT_ENABLE_ON    4'h9
`define TWT_PSEL_CONN    31
`define TWT_ERR_OVF      0
`define TWT_ERR_DATA_NACK_ERROR    2
`define TWT_ERR_OVR      3
`define TWT_EV_RXEND     0
`define TWT_EV_TXEND     1
`define TWT_EV_ERR       2
`define TWT_RST_PSEL     32'hffffffff
`define TWT_RST_CONFIG   2'h1
`define TWT_BITS_BYTE    4'h8

`endif

/* twt_pkg.sv */
// Purpose: types shared by the two-wire target files
// Assumes: nothing
// Notes:   state codes written out
`default_nettype none
package twt_pkg;
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_ADDR  = 3'b001,
		ST_WDATA = 3'b010,
		ST_RDATA = 3'b011,
		ST_ACK   = 3'b100,
		ST_MACK  = 3'b101
	} twt_state_t;
endpackage : twt_pkg
`default_nettype wire

/* twt_line_if.sv */
// Purpose: one synchronised bus line with its edges
// Assumes: single clock
// Notes:   src drives, dst reads
`default_nettype none
interface twt_line_if;
	logic lvl;
	logic rise;
	logic fall;
	modport src (output lvl, output rise, output fall);
	modport dst (input lvl, input rise, input fall);
endinterface : twt_line_if
`default_nettype wire

/* twt_sync.sv */
// Purpose: two-flop synchroniser with edge detection for one bus line
// Assumes: pin is asynchronous to clk
// Notes:   first flop feeds only the second
`default_nettype none
module twt_sync #(
	parameter logic IDLE_LVL = 1'b1
) (
	input  wire logic  clk,
	input  wire logic  reset,
	input  wire logic  pin_i,
	twt_line_if.src    line
);
	logic meta_r;
	logic sync_r;
	logic dly_r;

	always_ff @(posedge clk) begin
		if (reset) begin
			meta_r <= IDLE_LVL;
			sync_r <= IDLE_LVL;
			dly_r  <= IDLE_LVL;
		end else begin
			meta_r <= pin_i;
			sync_r <= meta_r;
			dly_r  <= sync_r;
		end
	end

	assign line.lvl  = sync_r;
	assign line.rise = sync_r & ~dly_r;
	assign line.fall = ~sync_r & dly_r;
endmodule : twt_sync
`default_nettype wire

/* twt_target.sv */
// Purpose: two-wire bus target with byte DMA and wishbone registers
// Assumes: memory answers well inside half a bus clock period
// Notes:   no clock stretching; bus lines oversampled at clk
//
// The implementer's own choice: the Wishbone interface to the registers.
`include "twt_regs.svh"
`default_nettype none
module twt_target import twt_pkg::*; #(
	parameter int MCW = 13
) (
	input  wire logic         clk,
	input  wire logic         reset,
	input  wire logic         wb_cyc_i,
	input  wire logic         wb_stb_i,
	input  wire logic         wb_we_i,
	input  wire logic [11:0]  wb_adr_i,
	input  wire logic [3:0]   wb_sel_i,
	input  wire logic [31:0]  wb_dat_i,
	output var  logic [31:0]  wb_dat_o,
	output var  logic         wb_ack_o,
	input  wire logic         scl_i,
	input  wire logic         sda_i,
	output var  logic         sda_o,
	output var  logic         sda_oe,
	output var  logic         mem_req,
	output var  logic         mem_we,
	output var  logic [31:0]  mem_addr,
	output var  logic [7:0]   mem_wdata,
	input  wire logic [7:0]   mem_rdata,
	input  wire logic         mem_ack,
	output var  logic         irq
);
	if (MCW < 1 || MCW > 31) begin : g_chk
		$error("twt_target: MCW out of range");
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [3:0]     en_r;
	logic           match_r;
	logic [31:0]    scl_sel_r;
	logic [31:0]    sda_sel_r;
	logic [31:0]    rx_ptr_r;
	logic [31:0]    tx_ptr_r;
	logic [MCW-1:0] rx_max_r;
	logic [MCW-1:0] tx_max_r;
	logic [MCW-1:0] rx_amt_r;
	logic [MCW-1:0] tx_amt_r;
	logic           rx_list_r;
	logic           tx_list_r;
	logic [6:0]     adr0_r;
	logic [6:0]     adr1_r;
	logic [1:0]     cfg_r;
	logic [7:0]     orc_r;
	logic [3:0]     err_r;
	logic [2:0]     evt_r;
	logic [2:0]     msk_r;

	twt_state_t     state_r;
	logic [3:0]     bit_r;
	logic [7:0]     sh_r;
	logic [7:0]     tx_r;
	logic           rw_r;
	logic           mack_r;
	logic           drive_r;
	logic           active_r;
	logic [MCW-1:0] rx_cnt_r;
	logic [MCW-1:0] tx_cnt_r;

	// ----------------------------------------
	// line sampling and conditions
	// ----------------------------------------
	twt_line_if scl_s ();
	twt_line_if sda_s ();

	twt_sync #(.IDLE_LVL(1'b1)) u_scl_sync (
		.clk   (clk),
		.reset (reset),
		.pin_i (scl_i),
		.line  (scl_s)
	);

	twt_sync #(.IDLE_LVL(1'b1)) u_sda_sync (
		.clk   (clk),
		.reset (reset),
		.pin_i (sda_i),
		.line  (sda_s)
	);

	logic scl_on, sda_on, scl_l, sda_l, scl_rise, scl_fall, sda_rise, sda_fall;
	logic start_ev, stop_ev, enabled, addr_dec, wr_dec, hit0, hit1, hit;
	logic rx_room, tx_room, fetch, txn_end;
	logic [MCW-1:0] tx_idx;

	// disconnected line reads idle high and is never driven
	assign scl_on   = ~scl_sel_r[`TWT_PSEL_CONN];
	assign sda_on   = ~sda_sel_r[`TWT_PSEL_CONN];
	assign scl_l    = scl_on ? scl_s.lvl : 1'b1;
	assign sda_l    = sda_on ? sda_s.lvl : 1'b1;
	assign scl_rise = scl_on & scl_s.rise;
	assign scl_fall = scl_on & scl_s.fall;
	assign sda_rise = sda_on & sda_s.rise;
	assign sda_fall = sda_on & sda_s.fall;
	assign start_ev = scl_l & sda_fall;
	assign stop_ev  = scl_l & sda_rise;
	assign enabled  = (en_r == `TWT_ENABLE_ON);

	assign addr_dec = (state_r == ST_ADDR) && scl_fall && (bit_r == `TWT_BITS_BYTE);
	assign wr_dec   = (state_r == ST_WDATA) && scl_fall && (bit_r == `TWT_BITS_BYTE);
	assign hit0     = cfg_r[0] && (sh_r[7:1] == adr0_r);
	assign hit1     = cfg_r[1] && (sh_r[7:1] == adr1_r);
	assign hit      = hit0 | hit1;
	assign rx_room  = rx_cnt_r < rx_max_r;
	assign tx_idx   = addr_dec ? '0 : tx_cnt_r;
	assign tx_room  = tx_idx < tx_max_r;
	assign fetch    = (addr_dec && hit && sh_r[0]) || ((state_r == ST_MACK) && scl_rise && !sda_l);
	assign txn_end  = active_r && (start_ev || stop_ev || !enabled);

	// ----------------------------------------
	// wishbone slave
	// ----------------------------------------
	logic        wb_req, wb_wr;
	logic [31:0] rd_val, wval, wclr;

	function automatic logic [31:0] twt_merge(input logic [31:0] old, input logic [31:0] dat,
		input logic [3:0] sel);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				res[8*i +: 8] = dat[8*i +: 8];
			end
		end
		return res;
	endfunction : twt_merge

	assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wb_wr  = wb_req & wb_we_i;

	always_comb begin
		case (wb_adr_i)
			`TWT_OFS_ERRSRC: rd_val = {28'h0, err_r};
			`TWT_OFS_MATCH:  rd_val = {31'h0, match_r};
			`TWT_OFS_ENABLE: rd_val = {28'h0, en_r};
			`TWT_OFS_SCLSEL: rd_val = scl_sel_r;
			`TWT_OFS_SDASEL: rd_val = sda_sel_r;
			`TWT_OFS_RXPTR:  rd_val = rx_ptr_r;
			`TWT_OFS_RXMAX:  rd_val = 32'(rx_max_r);
			`TWT_OFS_RXAMT:  rd_val = 32'(rx_amt_r);
			`TWT_OFS_RXLIST: rd_val = {31'h0, rx_list_r};
			`TWT_OFS_TXPTR:  rd_val = tx_ptr_r;
			`TWT_OFS_TXMAX:  rd_val = 32'(tx_max_r);
			`TWT_OFS_TXAMT:  rd_val = 32'(tx_amt_r);
			`TWT_OFS_TXLIST: rd_val = {31'h0, tx_list_r};
			`TWT_OFS_ADDR0:  rd_val = {25'h0, adr0_r};
			`TWT_OFS_ADDR1:  rd_val = {25'h0, adr1_r};
			`TWT_OFS_CONFIG: rd_val = {30'h0, cfg_r};
			`TWT_OFS_ORC:    rd_val = {24'h0, orc_r};
			`TWT_OFS_EVSTAT: rd_val = {29'h0, evt_r};
			`TWT_OFS_EVMASK: rd_val = {29'h0, msk_r};
			default:         rd_val = 32'h0;
		endcase
	end

	assign wval = twt_merge(rd_val, wb_dat_i, wb_sel_i);
	assign wclr = twt_merge(32'h0, wb_dat_i, wb_sel_i);

	// one wait state, then ack for exactly one cycle
	always_ff @(posedge clk) begin
		if (reset) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end else begin
			wb_ack_o <= wb_req;
			wb_dat_o <= (wb_req && !wb_we_i) ? rd_val : 32'h0;
		end
	end

	// ----------------------------------------
	// configuration written by software
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (reset) begin
			en_r      <= 4'h0;
			scl_sel_r <= `TWT_RST_PSEL;
			sda_sel_r <= `TWT_RST_PSEL;
			rx_max_r  <= '0;
			tx_max_r  <= '0;
			rx_list_r <= 1'b0;
			tx_list_r <= 1'b0;
			adr0_r    <= 7'h0;
			adr1_r    <= 7'h0;
			cfg_r     <= `TWT_RST_CONFIG;
			orc_r     <= 8'h0;
			msk_r     <= 3'h0;
		end else if (wb_wr) begin
			case (wb_adr_i)
				`TWT_OFS_ENABLE: en_r      <= wval[3:0];
				`TWT_OFS_SCLSEL: scl_sel_r <= wval;
				`TWT_OFS_SDASEL: sda_sel_r <= wval;
				`TWT_OFS_RXMAX:  rx_max_r  <= wval[MCW-1:0];
				`TWT_OFS_TXMAX:  tx_max_r  <= wval[MCW-1:0];
				`TWT_OFS_RXLIST: rx_list_r <= wval[0];
				`TWT_OFS_TXLIST: tx_list_r <= wval[0];
				`TWT_OFS_ADDR0:  adr0_r    <= wval[6:0];
				`TWT_OFS_ADDR1:  adr1_r    <= wval[6:0];
				`TWT_OFS_CONFIG: cfg_r     <= wval[1:0];
				`TWT_OFS_ORC:    orc_r     <= wval[7:0];
				`TWT_OFS_EVMASK: msk_r     <= wval[2:0];
				default: ;
			endcase
		end
	end

	// ----------------------------------------
	// buffer pointers, list advance
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (reset) begin
			rx_ptr_r <= 32'h0;
			tx_ptr_r <= 32'h0;
		end else if (txn_end && !rw_r && rx_list_r) begin
			rx_ptr_r <= rx_ptr_r + 32'(rx_max_r);
		end else if (txn_end && rw_r && tx_list_r) begin
			tx_ptr_r <= tx_ptr_r + 32'(tx_max_r);
		end else if (wb_wr && wb_adr_i == `TWT_OFS_RXPTR) begin
			rx_ptr_r <= wval;
		end else if (wb_wr && wb_adr_i == `TWT_OFS_TXPTR) begin
			tx_ptr_r <= wval;
		end
	end

	// ----------------------------------------
	// error and event flags, set beats clear
	// ----------------------------------------
	logic [3:0] err_set;
	logic [2:0] evt_set;
	assign err_set = {fetch && !tx_room, wr_dec && !rx_room, 1'b0, wr_dec && !rx_room};
	assign evt_set = {|err_set, txn_end && rw_r, txn_end && !rw_r};

	always_ff @(posedge clk) begin
		if (reset) begin
			err_r <= 4'h0;
			evt_r <= 3'h0;
		end else begin
			err_r <= (err_r & ~((wb_wr && wb_adr_i == `TWT_OFS_ERRSRC) ? wclr[3:0] : 4'h0)) | err_set;
			evt_r <= (evt_r & ~((wb_wr && wb_adr_i == `TWT_OFS_EVSTAT) ? wclr[2:0] : 3'h0)) | evt_set;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			irq <= 1'b0;
		end else begin
			irq <= |(evt_r & msk_r);
		end
	end

	// ----------------------------------------
	// bus protocol engine
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (reset) begin
			state_r  <= ST_IDLE;
			bit_r    <= 4'h0;
			sh_r     <= 8'h0;
			rw_r     <= 1'b0;
			mack_r   <= 1'b0;
			drive_r  <= 1'b0;
			active_r <= 1'b0;
			match_r  <= 1'b0;
		end else if (!enabled) begin
			state_r  <= ST_IDLE;
			drive_r  <= 1'b0;
			active_r <= 1'b0;
		end else if (start_ev) begin
			state_r  <= ST_ADDR;
			bit_r    <= 4'h0;
			drive_r  <= 1'b0;
			active_r <= 1'b0;
		end else if (stop_ev) begin
			state_r  <= ST_IDLE;
			drive_r  <= 1'b0;
			active_r <= 1'b0;
		end else begin
			case (state_r)
				ST_ADDR, ST_WDATA: begin
					if (scl_rise) begin
						sh_r  <= {sh_r[6:0], sda_l};
						bit_r <= bit_r + 4'h1;
					end else if (addr_dec) begin
						if (hit) begin
							match_r  <= hit1 && !hit0;
							rw_r     <= sh_r[0];
							active_r <= 1'b1;
							drive_r  <= 1'b1;
							state_r  <= ST_ACK;
						end else begin
							state_r  <= ST_IDLE;
						end
					end else if (wr_dec) begin
						drive_r <= rx_room;
						state_r <= ST_ACK;
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						bit_r   <= 4'h0;
						drive_r <= rw_r ? !tx_r[7] : 1'b0;
						state_r <= rw_r ? ST_RDATA : ST_WDATA;
					end
				end
				ST_RDATA: begin
					if (scl_fall) begin
						if (bit_r == 4'h7) begin
							drive_r <= 1'b0;
							state_r <= ST_MACK;
						end else begin
							drive_r <= !tx_r[3'h6 - bit_r[2:0]];
							bit_r   <= bit_r + 4'h1;
						end
					end
				end
				ST_MACK: begin
					if (scl_rise) begin
						mack_r <= !sda_l;
					end else if (scl_fall) begin
						bit_r   <= 4'h0;
						drive_r <= mack_r && !tx_r[7];
						state_r <= mack_r ? ST_RDATA : ST_IDLE;
					end
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// open drain: only ever pull low
	always_ff @(posedge clk) begin
		if (reset) begin
			sda_oe <= 1'b0;
			sda_o  <= 1'b0;
		end else begin
			sda_oe <= drive_r && sda_on && enabled;
			sda_o  <= 1'b0;
		end
	end

	// ----------------------------------------
	// byte counters and amounts
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (reset) begin
			rx_cnt_r <= '0;
			tx_cnt_r <= '0;
			rx_amt_r <= '0;
			tx_amt_r <= '0;
		end else begin
			if (addr_dec && hit) begin
				rx_cnt_r <= '0;
				tx_cnt_r <= (sh_r[0] && tx_room) ? MCW'(1) : '0;
			end else begin
				if (wr_dec && rx_room) rx_cnt_r <= rx_cnt_r + MCW'(1);
				if (fetch && tx_room)  tx_cnt_r <= tx_cnt_r + MCW'(1);
			end
			if (txn_end && !rw_r) rx_amt_r <= rx_cnt_r;
			if (txn_end && rw_r)  tx_amt_r <= tx_cnt_r;
		end
	end

	// ----------------------------------------
	// dma port
	// ----------------------------------------
	// pointers are trusted as given; no range check here
	always_ff @(posedge clk) begin
		if (reset) begin
			mem_req   <= 1'b0;
			mem_we    <= 1'b0;
			mem_addr  <= 32'h0;
			mem_wdata <= 8'h0;
			tx_r      <= 8'h0;
		end else begin
			if (mem_req && mem_ack) begin
				mem_req <= 1'b0;
				if (!mem_we) tx_r <= mem_rdata;
			end else if (wr_dec && rx_room) begin
				mem_req   <= 1'b1;
				mem_we    <= 1'b1;
				mem_addr  <= rx_ptr_r + 32'(rx_cnt_r);
				mem_wdata <= sh_r;
			end else if (fetch && tx_room) begin
				mem_req   <= 1'b1;
				mem_we    <= 1'b0;
				mem_addr  <= tx_ptr_r + 32'(tx_idx);
			end
			if (fetch && !tx_room) tx_r <= orc_r;
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	sequence seq_rx_full;
		wr_dec && !rx_room;
	endsequence
	sequence seq_over_read;
		fetch && !tx_room;
	endsequence
	sequence seq_end_write;
		txn_end && !rw_r;
	endsequence
	sequence seq_end_read;
		txn_end && rw_r;
	endsequence

	AST_DISABLED_IDLE: assert property (!enabled |=> state_r == ST_IDLE ##1 !sda_oe)
		else $error("target active while disabled");
	AST_MATCH_INDEX: assert property (addr_dec && hit |=> match_r == $past(hit1 && !hit0))
		else $error("match index wrong");
	AST_SCL_DISCONNECT: assert property (scl_sel_r[31] && state_r == ST_ADDR |=> bit_r == $past(bit_r))
		else $error("disconnected clock line counted bits");
	AST_SDA_DISCONNECT: assert property (sda_sel_r[31] [*2] |-> !sda_oe)
		else $error("disconnected data line driven");
	AST_RX_LIMIT: assert property (seq_rx_full |=> $stable(rx_cnt_r) && !(mem_req && mem_we && !$past(mem_req)))
		else $error("receive past maximum count");
	AST_RX_AMOUNT: assert property (seq_end_write |=> rx_amt_r == $past(rx_cnt_r))
		else $error("receive amount not recorded");
	AST_TX_LIMIT: assert property (seq_over_read |=> tx_cnt_r == $past(tx_idx))
		else $error("transmit past maximum count");
	AST_TX_AMOUNT: assert property (seq_end_read |=> tx_amt_r == $past(tx_cnt_r))
		else $error("transmit amount not recorded");
	AST_ADDR_GATED: assert property (addr_dec && !cfg_r[1] && sh_r[7:1] == adr1_r && !hit0 |=> !active_r)
		else $error("disabled address matched");
	AST_CFG_RESET: assert property ($fell(reset) |-> cfg_r == 2'h1 && en_r == 4'h0)
		else $error("reset values wrong");
	AST_FILL_CHAR: assert property (seq_over_read |=> tx_r == $past(orc_r))
		else $error("fill character not loaded");
	AST_ERR_FLAGS: assert property (seq_rx_full |=> err_r[0] && err_r[2] ##1 !sda_oe)
		else $error("overflow not flagged or byte acked");
endmodule : twt_target
`default_nettype wire

/* twt_ctl_model.sv */
// Purpose: behavioural bus controller facing the two-wire target
// Assumes: pull-up on the data line, resolved by the bench
// Notes:   clock line stands high outside frames
`default_nettype none
module twt_ctl_model (
	output var  logic scl,
	output var  logic sda_low,
	input  wire logic sda_line
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// bit timing, 125 ns link period
	// ----------------------------------------
	localparam real Q = 31.25;
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic bit_io(input logic b, output logic s);
		sda_low = ~b;
		#Q scl = 1'b1;
		#Q s = sda_line;
		#Q scl = 1'b0;
		#Q;
	endtask : bit_io
	task automatic start();
		sda_low = 1'b1;
		#Q scl = 1'b0;
		#Q;
	endtask : start
	task automatic stop();
		sda_low = 1'b1;
		#Q scl = 1'b1;
		#Q sda_low = 1'b0;
		#Q;
	endtask : stop
	// released data bit reads the resolved line, so a target pull-down shows, never a stale value
	task automatic put_byte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) bit_io(d[i], s);
		bit_io(1'b1, s);
		ack = ~s;
	endtask : put_byte
	task automatic get_byte(input logic mack, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, s);
			d[i] = s;
		end
		bit_io(~mack, s);
	endtask : get_byte
endmodule : twt_ctl_model
`default_nettype wire

/* twt_target_bench.sv */
// Purpose: self-checking bench of the two-wire target
// Assumes: memory answers one cycle after a request
// Notes:   registers reached over classic wishbone
`include "twt_regs.svh"
`default_nettype none
module twt_target_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, sda_o, sda_oe;
	logic        mem_req, mem_we, mem_ack, irq, scl, sda_low, sda_line;
	logic [11:0] wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, mem_addr;
	logic [7:0]  mem_wdata, mem_rdata;
	logic [7:0]  mem [256];
	int          error_cnt, comparisons;
	assign sda_line = ~(sda_low | sda_oe);
	twt_target uut (.clk(clk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.scl_i(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe), .mem_req(mem_req), .mem_we(mem_we),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .irq(irq));
	twt_ctl_model ctl (.scl(scl), .sda_low(sda_low), .sda_line(sda_line));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// ----------------------------------------
	// byte memory behind the dma port
	// ----------------------------------------
	always @(posedge clk) begin
		mem_ack <= mem_req & ~mem_ack;
		mem_rdata <= 8'h3c ^ mem_addr[7:0];
		if (mem_req & ~mem_ack & mem_we) mem[mem_addr[7:0]] <= mem_wdata;
	end
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : finish_test
	task automatic timeout();
		error_cnt++;
		$display("[FAIL] %0t wait ran out", $time);
		finish_test();
	endtask : timeout
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wb(input logic we, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		@(posedge clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		if (n >= 20) timeout();
	endtask : wb
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, q);
	endtask : wr
	task automatic rc(input logic [11:0] a, input logic [31:0] e);
		logic [31:0] q;
		wb(1'b0, a, 32'h0, q);
		chk(q, e);
	endtask : rc
	task automatic wait_irq();
		int n;
		n = 0;
		while (irq !== 1'b1 && n < 200) begin
			@(posedge clk);
			n++;
		end
		if (n >= 200) timeout();
	endtask : wait_irq
	task automatic irq_is(input logic e);
		repeat (3) @(posedge clk);
		chk({31'h0, irq}, {31'h0, e});
	endtask : irq_is
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset();
		logic a;
		rc(`TWT_OFS_ENABLE, 32'h0);
		rc(`TWT_OFS_SCLSEL, 32'hffffffff);
		rc(`TWT_OFS_SDASEL, 32'hffffffff);
		rc(`TWT_OFS_CONFIG, 32'h1);
		rc(`TWT_OFS_MATCH, 32'h0);
		rc(12'h5fc, 32'h0);
		wr(`TWT_OFS_RXAMT, 32'h55);
		rc(`TWT_OFS_RXAMT, 32'h0);
		wr(`TWT_OFS_ADDR0, 32'h52);
		wb_sel_i <= 4'he;
		wr(`TWT_OFS_ADDR0, 32'h7f);
		wb_sel_i <= 4'hf;
		rc(`TWT_OFS_ADDR0, 32'h52);
		wr(`TWT_OFS_ENABLE, 32'h9);
		ctl.start();
		ctl.put_byte(8'ha4, a);
		chk({31'h0, a}, 32'h0);
		ctl.stop();
		wr(`TWT_OFS_SCLSEL, 32'h3);
		wr(`TWT_OFS_SDASEL, 32'h4);
		rc(`TWT_OFS_SCLSEL, 32'h3);
		rc(`TWT_OFS_SDASEL, 32'h4);
		chk({31'h0, sda_o}, 32'h0);
		$display("test reset and pins done");
	endtask : t_reset
	task automatic t_write();
		logic a;
		wr(`TWT_OFS_RXPTR, 32'h40);
		wr(`TWT_OFS_RXMAX, 32'h2);
		wr(`TWT_OFS_RXLIST, 32'h1);
		wr(`TWT_OFS_EVMASK, 32'h1);
		ctl.start();
		ctl.put_byte(8'ha4, a);
		chk({31'h0, a}, 32'h1);
		ctl.put_byte(8'hc3, a);
		chk({31'h0, a}, 32'h1);
		ctl.put_byte(8'h5a, a);
		chk({31'h0, a}, 32'h1);
		ctl.put_byte(8'h77, a);
		chk({31'h0, a}, 32'h0);
		ctl.stop();
		wait_irq();
		chk({24'h0, mem[8'h40]}, 32'hc3);
		chk({24'h0, mem[8'h41]}, 32'h5a);
		chk({24'h0, mem[8'h42]}, 32'h0);
		rc(`TWT_OFS_RXAMT, 32'h2);
		rc(`TWT_OFS_ERRSRC, 32'h5);
		rc(`TWT_OFS_RXPTR, 32'h42);
		rc(`TWT_OFS_MATCH, 32'h0);
		wr(`TWT_OFS_ERRSRC, 32'h5);
		rc(`TWT_OFS_ERRSRC, 32'h0);
		wr(`TWT_OFS_EVMASK, 32'h0);
		irq_is(1'b0);
		wr(`TWT_OFS_EVMASK, 32'h1);
		irq_is(1'b1);
		wr(`TWT_OFS_EVSTAT, 32'h7);
		irq_is(1'b0);
		$display("test write done");
	endtask : t_write
	task automatic t_read();
		logic       a;
		logic [7:0] d;
		wr(`TWT_OFS_ADDR1, 32'h31);
		wr(`TWT_OFS_CONFIG, 32'h3);
		wr(`TWT_OFS_TXPTR, 32'h80);
		wr(`TWT_OFS_TXMAX, 32'h1);
		wr(`TWT_OFS_ORC, 32'he7);
		wr(`TWT_OFS_EVMASK, 32'h2);
		ctl.start();
		ctl.put_byte(8'h63, a);
		chk({31'h0, a}, 32'h1);
		ctl.get_byte(1'b1, d);
		chk({24'h0, d}, 32'hbc);
		ctl.get_byte(1'b0, d);
		chk({24'h0, d}, 32'he7);
		ctl.stop();
		wait_irq();
		rc(`TWT_OFS_MATCH, 32'h1);
		rc(`TWT_OFS_TXAMT, 32'h1);
		rc(`TWT_OFS_ERRSRC, 32'h8);
		rc(`TWT_OFS_TXPTR, 32'h80);
		wr(`TWT_OFS_EVSTAT, 32'h7);
		$display("test read done");
	endtask : t_read
	task automatic t_refuse();
		logic a;
		wr(`TWT_OFS_CONFIG, 32'h1);
		ctl.start();
		ctl.put_byte(8'h62, a);
		chk({31'h0, a}, 32'h0);
		ctl.stop();
		wr(`TWT_OFS_ENABLE, 32'h0);
		ctl.start();
		ctl.put_byte(8'ha4, a);
		chk({31'h0, a}, 32'h0);
		ctl.stop();
		$display("test refuse done");
	endtask : t_refuse
	initial begin
		#100us;
		timeout();
	end
	initial begin
		error_cnt = 0;
		comparisons = 0;
		reset = 1'b1;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 12'h0;
		wb_sel_i = 4'hf;
		wb_dat_i = 32'h0;
		mem_ack = 1'b0;
		mem_rdata = 8'h0;
		foreach (mem[i]) mem[i] = 8'h0;
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		t_reset();
		t_write();
		t_read();
		t_refuse();
		finish_test();
	end
endmodule : twt_target_bench
`default_nettype wire
